// ### core/dbhrp_consts.svh
// Constants of the host RAM port.
// Assumes inclusion by the port and its bench.
`ifndef DBHRP_CONSTS_SVH
`define DBHRP_CONSTS_SVH

// ------------------------------------------------------------------
// Register select codes (index register bits 7..2).
// ------------------------------------------------------------------
`define DBHRP_SEL_BANK_CTRL 6'h00
`define DBHRP_SEL_MEM_CTRL 6'h02
`define DBHRP_SEL_STATUS 6'h03
`define DBHRP_SEL_ADDRESS 6'h05
`define DBHRP_SEL_DATA 6'h06

// ------------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------------
`define DBHRP_MCR_LOCK 7
`define DBHRP_MCR_WRITE 5
`define DBHRP_MCR_READ 3
`define DBHRP_MCR_DIR 0
`define DBHRP_BCR_DMD 11
`define DBHRP_BCR_DMA_REQUEST_POLARITY 10
`define DBHRP_BCR_BMD 9
`define DBHRP_BCR_BANK_SELECT 8
`define DBHRP_BCR_BOOT 5
`define DBHRP_BCR_EDN 1
`define DBHRP_ADDR_STEP 8'h01
`define DBHRP_USER_MASK 32'h0000_FFFF
`define DBHRP_BCR_WMASK 32'h0000_0F02
`define DBHRP_BCR_RESET 32'h0000_0040
`define DBHRP_MCR_WMASK 32'h0000_0081

`endif

// ### core/dbhrp_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and an active low asynchronous reset.
module dbhrp_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Fill side.
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Drain side.
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    // Handshake terms; full and empty follow the occupancy count.
    assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (count_reg != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr_reg];

    // Storage array, written only on a push.
    always_ff @(posedge i_clock)
    begin
        if (push)
        begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    // Pointers and count.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dbhrp_fifo

// ### core/dbhrp_pkg.sv
// Types shared by the dual bank host RAM port.
// Assumes the constants header sits beside it in core/.
package dbhrp_pkg;

    // ------------------------------------------------------------------
    // Host bus request carried as one packed word.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic index_wr;
        logic data_wr;
        logic data_rd;
        logic [15:0] wdata;
    } dbhrp_host_req_t;

    // CPU access to the shared RAM window.
    typedef struct packed {
        logic en;
        logic wr;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } dbhrp_cpu_req_t;

    // Host RAM engine states.
    typedef enum logic [1:0] {
        DBHRP_IDLE,
        DBHRP_READ,
        DBHRP_WAIT
    } dbhrp_state_t;

endpackage : dbhrp_pkg

// ### core/dbhrp_port.sv
// Dual bank host RAM port: indexed host registers, two RAM banks.
// Assumes host strobes are synchronous one-cycle pulses on i_clock.
`include "dbhrp_consts.svh"

module dbhrp_port
    import dbhrp_pkg::*;
#(
    parameter int WORDS = 256,
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Boot strap, sampled after reset release.
    input wire logic i_boot_from_ram,
    // Host bus.
    input wire dbhrp_host_req_t i_host,
    output logic [15:0] o_host_rdata,
    output logic o_host_busy,
    output logic o_dma_request_pin,
    // CPU bus.
    input wire dbhrp_cpu_req_t i_cpu,
    input wire logic i_cpu_bank_ctrl_wr,
    input wire logic i_cpu_status_wr,
    input wire logic [31:0] i_cpu_ctrl_wdata,
    output logic [31:0] o_cpu_rdata,
    output logic o_cpu_ready,
    output logic [31:0] o_cpu_status,
    output logic [31:0] o_cpu_bank_ctrl
);
    // ------------------------------------------------------------------
    // Storage and registers.
    // ------------------------------------------------------------------
    logic [31:0] bank0 [WORDS];
    logic [31:0] bank1 [WORDS];
    logic [7:0] index_reg;
    logic [7:0] addr_reg;
    logic [31:0] data_reg;
    logic [7:0] mcr_reg;
    logic [15:0] status_reg;
    logic [31:0] bcr_reg;
    logic boot_reg;
    logic boot_seen_reg;
    logic [15:0] host_rdata_reg;
    logic [31:0] cpu_rdata_reg;
    logic cpu_ready_reg;
    dbhrp_state_t state_reg;
    logic host_bank;
    logic cpu_bank;
    logic conflict;
    logic [31:0] fifo_rdata;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [31:0] sel_word;
    logic [31:0] merged;
    logic data_access;
    logic ram_wr_req;
    logic ram_rd_req;

    // Replace one 16-bit half of a word; position 0 is the low half.
    function automatic logic [31:0] put_half(input logic [31:0] w, input logic hi,
                                             input logic [15:0] v);
        put_half = hi ? {v, w[15:0]} : {w[31:16], v};
    endfunction : put_half

    // Byte swap for little-endian CPU reads.
    function automatic logic [31:0] swap32(input logic [31:0] w);
        swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap32

    // ------------------------------------------------------------------
    // Bank steering and conflict.
    // ------------------------------------------------------------------
    assign host_bank = bcr_reg[`DBHRP_BCR_BANK_SELECT];
    assign cpu_bank = bcr_reg[`DBHRP_BCR_BANK_SELECT] ^ bcr_reg[`DBHRP_BCR_BMD];
    // Host RAM writes leave the FIFO; they stall the CPU on the same bank.
    assign fifo_pop = fifo_out_valid;
    assign conflict = fifo_pop && i_cpu.en && (cpu_bank == host_bank);

    // Current selected register, as the host sees it.
    always_comb
    begin
        case (index_reg[7:2])
            `DBHRP_SEL_BANK_CTRL: sel_word = o_cpu_bank_ctrl;
            `DBHRP_SEL_MEM_CTRL: sel_word = {24'h00_0000, mcr_reg};
            `DBHRP_SEL_STATUS: sel_word = o_cpu_status;
            `DBHRP_SEL_ADDRESS: sel_word = {22'h00_0000, addr_reg, 2'b00};
            `DBHRP_SEL_DATA: sel_word = data_reg;
            default: sel_word = 32'h0000_0000;
        endcase
    end

    assign merged = put_half(sel_word, index_reg[1], i_host.wdata);
    assign data_access = (index_reg[7:2] == `DBHRP_SEL_DATA) && (i_host.data_wr || i_host.data_rd);
    assign ram_wr_req = i_host.data_wr && (index_reg[7:2] == `DBHRP_SEL_MEM_CTRL)
                        && i_host.wdata[`DBHRP_MCR_WRITE] && !index_reg[1];
    assign ram_rd_req = i_host.data_wr && (index_reg[7:2] == `DBHRP_SEL_MEM_CTRL)
                        && i_host.wdata[`DBHRP_MCR_READ] && !index_reg[1];
    // Busy while a fetch is pending or the FIFO is full.
    assign o_host_busy = (state_reg != DBHRP_IDLE) || !fifo_in_ready;

    // ------------------------------------------------------------------
    // Write queue: stored words leave one per cycle; the bank port always takes them first.
    // ------------------------------------------------------------------
    dbhrp_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_in_valid(ram_wr_req && fifo_in_ready),
        .o_in_ready(fifo_in_ready),
        .i_in_data({addr_reg, data_reg[23:0]}),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(1'b1),
        .o_out_data(fifo_rdata)
    );
    // The top data byte rides in a shadow queue beside the FIFO.
    logic [7:0] top_q [FIFO_DEPTH];
    logic [$clog2(FIFO_DEPTH)-1:0] top_wr_reg;
    logic [$clog2(FIFO_DEPTH)-1:0] top_rd_reg;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            top_wr_reg <= '0;
            top_rd_reg <= '0;
        end
        else
        begin
            if (ram_wr_req && fifo_in_ready)
            begin
                top_wr_reg <= top_wr_reg + 1'b1;
            end
            if (fifo_pop)
            begin
                top_rd_reg <= top_rd_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (ram_wr_req && fifo_in_ready)
        begin
            top_q[top_wr_reg] <= data_reg[31:24];
        end
    end

    // ------------------------------------------------------------------
    // Shared RAM banks: host queue first, CPU when free.
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock)
    begin
        if (fifo_pop)
        begin
            if (host_bank)
            begin
                bank1[fifo_rdata[31:24]] <= {top_q[top_rd_reg], fifo_rdata[23:0]};
            end
            else
            begin
                bank0[fifo_rdata[31:24]] <= {top_q[top_rd_reg], fifo_rdata[23:0]};
            end
        end
        if (i_cpu.en && i_cpu.wr && !conflict)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (i_cpu.be[b])
                begin
                    if (cpu_bank)
                    begin
                        bank1[i_cpu.addr][b*8 +: 8] <= i_cpu.wdata[b*8 +: 8];
                    end
                    else
                    begin
                        bank0[i_cpu.addr][b*8 +: 8] <= i_cpu.wdata[b*8 +: 8];
                    end
                end
            end
        end
    end

    // CPU read path; little-endian mode swaps the bytes of the word.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cpu_rdata_reg <= 32'h0000_0000;
            cpu_ready_reg <= 1'b0;
        end
        else
        begin
            cpu_ready_reg <= i_cpu.en && !conflict;
            if (i_cpu.en && !i_cpu.wr && !conflict)
            begin
                cpu_rdata_reg <= bcr_reg[`DBHRP_BCR_EDN]
                    ? swap32(cpu_bank ? bank1[i_cpu.addr] : bank0[i_cpu.addr])
                    : (cpu_bank ? bank1[i_cpu.addr] : bank0[i_cpu.addr]);
            end
        end
    end
    assign o_cpu_rdata = cpu_rdata_reg;
    assign o_cpu_ready = cpu_ready_reg;

    // ------------------------------------------------------------------
    // Host registers.
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            index_reg <= 8'h00;
            addr_reg <= 8'h00;
            data_reg <= 32'h0000_0000;
            mcr_reg <= 8'h00;
            state_reg <= DBHRP_IDLE;
        end
        else
        begin
            if (i_host.index_wr)
            begin
                index_reg <= i_host.wdata[7:0];
            end
            if (i_host.data_wr && index_reg[7:2] == `DBHRP_SEL_ADDRESS)
            begin
                addr_reg <= merged[9:2];
            end
            if (i_host.data_wr && index_reg[7:2] == `DBHRP_SEL_DATA)
            begin
                data_reg <= merged;
            end
            if (i_host.data_wr && index_reg[7:2] == `DBHRP_SEL_MEM_CTRL)
            begin
                mcr_reg <= merged[7:0] & 8'(`DBHRP_MCR_WMASK);
            end
            // Auto-step counts a full word once per low-half access.
            if (data_access && !index_reg[1] && mcr_reg[`DBHRP_MCR_LOCK]
                && !mcr_reg[`DBHRP_MCR_DIR])
            begin
                addr_reg <= addr_reg + `DBHRP_ADDR_STEP;
            end
            case (state_reg)
                DBHRP_IDLE:
                begin
                    if (ram_rd_req)
                    begin
                        state_reg <= DBHRP_WAIT;
                    end
                end
                DBHRP_WAIT:
                begin
                    // Pending writes drain first so the read sees them.
                    if (!fifo_out_valid)
                    begin
                        state_reg <= DBHRP_READ;
                    end
                end
                DBHRP_READ:
                begin
                    data_reg <= host_bank ? bank1[addr_reg] : bank0[addr_reg];
                    state_reg <= DBHRP_IDLE;
                end
                default: state_reg <= DBHRP_IDLE;
            endcase
        end
    end

    // Host read data is registered on each data-port read.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            host_rdata_reg <= 16'h0000;
        end
        else if (i_host.data_rd)
        begin
            host_rdata_reg <= index_reg[1] ? sel_word[31:16] : sel_word[15:0];
        end
    end
    assign o_host_rdata = host_rdata_reg;

    // ------------------------------------------------------------------
    // Shared status flags; both sides write, the host last in a tie.
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            status_reg <= 16'h0000;
        end
        else if (i_host.data_wr && index_reg[7:2] == `DBHRP_SEL_STATUS && !index_reg[1])
        begin
            status_reg <= i_host.wdata;
        end
        else if (i_cpu_status_wr)
        begin
            status_reg <= i_cpu_ctrl_wdata[15:0];
        end
    end
    assign o_cpu_status = {16'h0000, status_reg};

    // ------------------------------------------------------------------
    // Bank and mode control; boot level caught once after reset release.
    // ------------------------------------------------------------------
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            bcr_reg <= `DBHRP_BCR_RESET;
            boot_reg <= 1'b0;
            boot_seen_reg <= 1'b0;
        end
        else
        begin
            if (!boot_seen_reg)
            begin
                boot_reg <= i_boot_from_ram;
                boot_seen_reg <= 1'b1;
            end
            if (i_host.data_wr && index_reg[7:2] == `DBHRP_SEL_BANK_CTRL)
            begin
                bcr_reg <= (merged & `DBHRP_BCR_WMASK) | `DBHRP_BCR_RESET;
            end
            else if (i_cpu_bank_ctrl_wr)
            begin
                bcr_reg <= (i_cpu_ctrl_wdata & `DBHRP_BCR_WMASK) | `DBHRP_BCR_RESET;
            end
        end
    end
    assign o_cpu_bank_ctrl = bcr_reg | {26'h000_0000, boot_reg, 5'h00};

    // DMA request: follows queue space, also gated by an idle engine when DMD is set; polarity inverts.
    assign o_dma_request_pin = bcr_reg[`DBHRP_BCR_DMA_REQUEST_POLARITY]
        ^ (bcr_reg[`DBHRP_BCR_DMD] ? (fifo_in_ready && state_reg == DBHRP_IDLE)
                                   : fifo_in_ready);
endmodule : dbhrp_port

// ### sim/dbhrp_host.sv
// Host processor model driving the indexed register port.
// Assumes the bench calls its tasks from one process at a time.
`include "dbhrp_consts.svh"
// ----
// Host model.
// ----
module dbhrp_host
    import dbhrp_pkg::*;
(
    // Clock.
    input wire logic i_clock,
    // Port answers.
    input wire logic i_busy,
    input wire logic [15:0] i_rdata,
    // Requests to the port.
    output dbhrp_host_req_t o_host
);
    timeunit 1ns;
    timeprecision 1ps;

    initial o_host = '0;

    // One-cycle strobe once busy is low; idle data is inverted.
    task automatic pulse(input int k, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge i_clock);
        while (i_busy !== 1'h0 && n < 200)
        begin
            @(negedge i_clock);
            n++;
        end
        o_host = {k == 0, k == 1, k == 2, d};
        @(negedge i_clock);
        o_host = {3'h0, ~d};
    endtask : pulse

    // Index first, then the data access on the chosen half.
    task automatic wr_reg(input logic [5:0] s, input logic h, input logic [15:0] d);
        pulse(0, {8'h00, s, h, 1'h0});
        pulse(1, d);
    endtask : wr_reg

    task automatic rd_reg(input logic [5:0] s, input logic h, output logic [15:0] q);
        pulse(0, {8'h00, s, h, 1'h0});
        pulse(2, 16'h0000);
        @(negedge i_clock);
        q = i_rdata;
    endtask : rd_reg

    // Upper half first: the auto step follows the low half.
    task automatic wr32(input logic [5:0] s, input logic [31:0] v);
        wr_reg(s, 1'h1, v[31:16]);
        wr_reg(s, 1'h0, v[15:0]);
    endtask : wr32

    task automatic rd32(input logic [5:0] s, output logic [31:0] v);
        logic [15:0] hi;
        logic [15:0] lo;
        rd_reg(s, 1'h1, hi);
        rd_reg(s, 1'h0, lo);
        v = {hi, lo};
    endtask : rd32

    task automatic store(input logic [15:0] a, input logic [31:0] v);
        wr_reg(`DBHRP_SEL_ADDRESS, 1'h0, a);
        wr32(`DBHRP_SEL_DATA, v);
        wr_reg(`DBHRP_SEL_MEM_CTRL, 1'h0, 16'h0020);
    endtask : store

    task automatic fetch(input logic [15:0] a, output logic [31:0] v);
        wr_reg(`DBHRP_SEL_ADDRESS, 1'h0, a);
        wr_reg(`DBHRP_SEL_MEM_CTRL, 1'h0, 16'h0008);
        rd32(`DBHRP_SEL_DATA, v);
    endtask : fetch

    // One download chunk; the last also raises the end flag.
    task automatic chunk(input logic [15:0] n, input logic [31:0] w, input logic last);
        logic [15:0] f;
        f = 16'h0000;
        while (f[0] !== 1'h1) rd_reg(`DBHRP_SEL_STATUS, 1'h0, f);
        store(16'h0000, {16'h0000, n});
        store(16'h0004, w);
        wr_reg(`DBHRP_SEL_STATUS, 1'h0, 16'h0000);
        if (last)
        begin
            f = 16'h0000;
            while (f[0] !== 1'h1) rd_reg(`DBHRP_SEL_STATUS, 1'h0, f);
            wr_reg(`DBHRP_SEL_STATUS, 1'h0, 16'h0002);
        end
    endtask : chunk
endmodule : dbhrp_host

// ### sim/dbhrp_port_chk.sv
// Concurrent checks on the port, attached by bind.
// Assumes one clock and an active low asynchronous reset.
// ----
// Port checker.
// ----
module dbhrp_port_chk
    import dbhrp_pkg::*;
(
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_rst_n,
    // Host side.
    input wire dbhrp_host_req_t i_host,
    input wire logic [15:0] o_host_rdata,
    input wire logic o_host_busy,
    input wire logic o_dma_request_pin,
    // CPU side.
    input wire dbhrp_cpu_req_t i_cpu,
    input wire logic i_cpu_bank_ctrl_wr,
    input wire logic i_cpu_status_wr,
    input wire logic [31:0] i_cpu_ctrl_wdata,
    input wire logic o_cpu_ready,
    input wire logic [31:0] o_cpu_status,
    input wire logic [31:0] o_cpu_bank_ctrl
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    AST_STATUS_RESV: assert property (o_cpu_status[31:16] == 16'h0000)
        else $error("status upper half not zero");
    AST_DMA_PIN: assert property (
        !o_host_busy |-> o_dma_request_pin == !o_cpu_bank_ctrl[10])
        else $error("dma pin level wrong");
    // A same-cycle host data write wins; such cycles are left out.
    AST_STATUS_WR: assert property (
        i_cpu_status_wr && !i_host.data_wr
        |=> ##1 o_cpu_status[15:0] == $past(i_cpu_ctrl_wdata[15:0], 2))
        else $error("cpu status write lost");
    AST_BANK_WR: assert property (
        i_cpu_bank_ctrl_wr && !i_host.data_wr
        |=> ##1 o_cpu_bank_ctrl[11:8] == $past(i_cpu_ctrl_wdata[11:8], 2)
        && o_cpu_bank_ctrl[1] == $past(i_cpu_ctrl_wdata[1], 2))
        else $error("bank control write lost");
    AST_CPU_SERVE: assert property ($rose(i_cpu.en) |-> ##[1:60] o_cpu_ready)
        else $error("cpu access never served");
    AST_READY_CAUSE: assert property (o_cpu_ready |-> $past(i_cpu.en))
        else $error("cpu ready without access");
    AST_FETCH_END: assert property ($rose(o_host_busy) |-> ##[1:80] !o_host_busy)
        else $error("host busy stuck");
    AST_RDATA_HOLD: assert property (
        !i_host.data_rd && !$past(i_host.data_rd) |=> $stable(o_host_rdata))
        else $error("host read data moved");
endmodule : dbhrp_port_chk

bind dbhrp_port dbhrp_port_chk dbhrp_port_chk_i (
    .i_clock, .i_rst_n, .i_host, .o_host_rdata, .o_host_busy, .o_dma_request_pin,
    .i_cpu, .i_cpu_bank_ctrl_wr, .i_cpu_status_wr, .i_cpu_ctrl_wdata, .o_cpu_ready,
    .o_cpu_status, .o_cpu_bank_ctrl
);

// ### sim/test_dbhrp_port.sv
// Self-checking bench for the dual bank host RAM port.
// Assumes the host model and checker compile first.
`include "dbhrp_consts.svh"
// ----
// Bench top.
// ----
module test_dbhrp_port
    import dbhrp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock = 1'h0;
    logic i_rst_n = 1'h0;
    logic i_boot_from_ram = 1'h0;
    dbhrp_host_req_t i_host;
    dbhrp_cpu_req_t i_cpu = '0;
    logic i_cpu_bank_ctrl_wr = 1'h0;
    logic i_cpu_status_wr = 1'h0;
    logic [31:0] i_cpu_ctrl_wdata = 32'h0000_0000;
    logic [15:0] o_host_rdata;
    logic o_host_busy;
    logic o_dma_request_pin;
    logic o_cpu_ready;
    logic [31:0] o_cpu_rdata;
    logic [31:0] o_cpu_status;
    logic [31:0] o_cpu_bank_ctrl;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_cyc = 0;
    int seed = 78;
    logic [31:0] x [2];
    logic [31:0] v;
    logic [31:0] r;
    logic [15:0] h;

    dbhrp_port dbhrp_port_i (.i_clock, .i_rst_n, .i_boot_from_ram, .i_host, .o_host_rdata,
        .o_host_busy, .o_dma_request_pin, .i_cpu, .i_cpu_bank_ctrl_wr, .i_cpu_status_wr,
        .i_cpu_ctrl_wdata, .o_cpu_rdata, .o_cpu_ready, .o_cpu_status, .o_cpu_bank_ctrl);
    dbhrp_host dbhrp_host_i (.i_clock, .i_busy(o_host_busy), .i_rdata(o_host_rdata),
        .o_host(i_host));

    // Free running 50 MHz clock.
    always #10 i_clock = ~i_clock;

    // Cycle ceiling, well above the run's length.
    always @(posedge i_clock)
    begin
        n_cyc++;
        if (n_cyc == 40000)
        begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        $display("mismatches %0d checks %0d", n_mismatch, n_checks);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    // CPU access held until ready; a host hit may stall it.
    task automatic cpu(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int k;
        k = 0;
        @(negedge i_clock);
        i_cpu = {1'h1, w, a, 4'hF, d};
        @(negedge i_clock);
        while (o_cpu_ready !== 1'h1 && k < 100)
        begin
            @(negedge i_clock);
            k++;
        end
        q = o_cpu_rdata;
        i_cpu = {1'h0, w, a, 4'hF, ~d};
    endtask : cpu

    // CPU write of status (s set) or bank control.
    task automatic ctl(input logic s, input logic [31:0] d);
        @(negedge i_clock);
        i_cpu_bank_ctrl_wr = !s;
        i_cpu_status_wr = s;
        i_cpu_ctrl_wdata = d;
        @(negedge i_clock);
        i_cpu_bank_ctrl_wr = 1'h0;
        i_cpu_status_wr = 1'h0;
        @(negedge i_clock);
    endtask : ctl

    function automatic logic [31:0] swap32(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction : swap32

    function automatic logic [31:0] bctl(input logic b, input logic [31:0] w);
        return 32'h0000_0040 | {26'h0, b, 5'h00} | (w & `DBHRP_BCR_WMASK);
    endfunction : bctl

    // Second reset follows the first pass's checks, with the boot strap set.
    initial
    begin
        for (int b = 0; b < 2; b++)
        begin
            i_rst_n = 1'h0;
            i_boot_from_ram = b[0];
            repeat (2) @(negedge i_clock);
            i_rst_n = 1'h1;
            repeat (2) @(negedge i_clock);
            chk_word(o_cpu_bank_ctrl, bctl(b[0], 0));
            dbhrp_host_i.rd_reg(`DBHRP_SEL_BANK_CTRL, 1'h0, h);
            chk_word({16'h0000, h}, bctl(b[0], 0));
        end
        r = $random(seed);
        ctl(1'h1, r);
        chk_word(o_cpu_status, {16'h0000, r[15:0]});
        dbhrp_host_i.rd_reg(`DBHRP_SEL_STATUS, 1'h0, h);
        chk_word({16'h0000, h}, {16'h0000, r[15:0]});
        h = 16'($random(seed));
        dbhrp_host_i.wr_reg(`DBHRP_SEL_STATUS, 1'h1, 16'hFFFF);
        dbhrp_host_i.wr_reg(`DBHRP_SEL_STATUS, 1'h0, h);
        @(negedge i_clock);
        chk_word(o_cpu_status, {16'h0000, h});
        dbhrp_host_i.wr_reg(`DBHRP_SEL_ADDRESS, 1'h0, 16'hFFFF);
        dbhrp_host_i.rd32(`DBHRP_SEL_ADDRESS, v);
        chk_word(v, 32'h0000_03FC);
        // Both ends of the bank, both directions.
        for (int i = 0; i < 4; i++)
        begin
            v = $random(seed);
            dbhrp_host_i.store(16'(i * 340), v);
            cpu(1'h0, 8'(i * 85), r, r);
            chk_word(r, v);
            cpu(1'h1, 8'(i * 85), ~v, r);
            dbhrp_host_i.fetch(16'(i * 340), r);
            chk_word(r, ~v);
        end
        dbhrp_host_i.wr_reg(`DBHRP_SEL_MEM_CTRL, 1'h0, 16'h0080);
        dbhrp_host_i.wr_reg(`DBHRP_SEL_ADDRESS, 1'h0, 16'h0010);
        dbhrp_host_i.wr_reg(`DBHRP_SEL_DATA, 1'h0, h);
        dbhrp_host_i.rd_reg(`DBHRP_SEL_DATA, 1'h0, h);
        dbhrp_host_i.rd32(`DBHRP_SEL_ADDRESS, v);
        chk_word(v, 32'h0000_0018);
        dbhrp_host_i.wr_reg(`DBHRP_SEL_MEM_CTRL, 1'h0, 16'h0081);
        dbhrp_host_i.wr_reg(`DBHRP_SEL_DATA, 1'h0, h);
        dbhrp_host_i.rd32(`DBHRP_SEL_ADDRESS, v);
        chk_word(v, 32'h0000_0018);
        dbhrp_host_i.wr_reg(`DBHRP_SEL_MEM_CTRL, 1'h0, 16'h0000);
        for (int b = 0; b < 2; b++)
        begin
            x[b] = $random(seed);
            ctl(1'h0, 32'(b) << 8);
            cpu(1'h1, 8'h03, x[b], r);
        end
        for (int b = 0; b < 2; b++)
        begin
            ctl(1'h0, 32'h0000_0200 | (32'(b) << 8));
            chk_word(o_cpu_bank_ctrl, bctl(1'h1, 32'h0000_0200 | (32'(b) << 8)));
            dbhrp_host_i.fetch(16'h000C, r);
            chk_word(r, x[b]);
            cpu(1'h0, 8'h03, r, r);
            chk_word(r, x[1 - b]);
        end
        ctl(1'h0, 32'h0000_0002);
        cpu(1'h0, 8'h03, r, r);
        chk_word(r, swap32(x[0]));
        for (int m = 0; m < 4; m++)
        begin
            ctl(1'h0, 32'(m) << 10);
            chk_word({31'h0, o_dma_request_pin}, {31'h0, !m[0]});
        end
        ctl(1'h1, 32'h0000_0000);
        v = $random(seed);
        // Double-buffered download over both banks.
        fork
            begin
                dbhrp_host_i.chunk(16'h0004, v, 1'h0);
                dbhrp_host_i.chunk(16'h0004, ~v, 1'h1);
            end
            begin
                for (int b = 0; b < 2; b++)
                begin
                    ctl(1'h0, 32'h0000_0200 | (32'(b) << 8));
                    cpu(1'h1, 8'h00, 32'h0000_0000, r);
                end
                ctl(1'h1, 32'h0000_0001);
                for (int c = 0; c < 2; c++)
                begin
                    while (o_cpu_status[0] !== 1'h0) @(negedge i_clock);
                    ctl(1'h0, 32'h0000_0200 | (32'(c) << 8));
                    ctl(1'h1, 32'h0000_0001);
                    cpu(1'h0, 8'h00, r, r);
                    chk_word(r, 32'h0000_0004);
                    cpu(1'h0, 8'h01, r, r);
                    chk_word(r, c == 0 ? v : ~v);
                    cpu(1'h1, 8'h00, 32'h0000_0000, r);
                end
            end
        join
        repeat (3) @(negedge i_clock);
        chk_word(o_cpu_status, 32'h0000_0002);
        complete_run();
    end
endmodule : test_dbhrp_port
